// *** dv/msq_host_model.sv ***
// Purpose: host partner model, frames the link and raises wake requests
// Assumes: link clock idles low, host samples miso on rising lclk edges
// Notes: lclk toggles only inside frames, with a 64 ns period that is unrelated to clk
`default_nettype none
module msq_host_model (
   input  wire logic clk,
   input  wire logic miso,
   output logic      ss_n,
   output logic      lclk,
   output logic      wake_rd,
   output logic      wake_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial
   begin
      ss_n    = 1'b1;
      lclk    = 1'b0;
      wake_rd = 1'b0;
      wake_wr = 1'b0;
   end
   // read nbits of the packet; select leads the first edge by 40 clk
   task automatic fetch(input int nbits, output logic [31:0] pkt);
      pkt = 32'h0;
      @(posedge clk) ss_n <= 1'b0;
      repeat (40) @(posedge clk);
      #7;
      for (int i = 0; i < nbits; i++)
      begin
         #32 lclk = 1'b1;
         pkt[31-i] = miso;
         #32 lclk = 1'b0;
      end
      #100;
      @(posedge clk) ss_n <= 1'b1;
      repeat (80) @(posedge clk);
   endtask
   // wake pin pulse from the outside address decoder
   task automatic i2c_wake(input logic rd);
      @(posedge clk);
      wake_rd <= rd;
      wake_wr <= !rd;
      repeat (6) @(posedge clk);
      wake_rd <= 1'b0;
      wake_wr <= 1'b0;
   endtask
   // select low with no clock edges, the rise starts the measurement
   task automatic spi_wake();
      @(posedge clk) ss_n <= 1'b0;
      repeat (400) @(posedge clk);
      ss_n <= 1'b1;
   endtask
endmodule // msq_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self-checking bench of the measurement sequencer
// Assumes: CLK_PER_US of 4 shortens every duration tenfold
// Notes: timing figures accepted within 2 percent of typical
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPU = 4;
   logic clk, srst, cfg_load, cfg_fast_clk, cfg_sleep, cfg_i2c, cfg_long_int;
   logic [1:0]  cfg_rate;
   logic [13:0] bridge_in;
   logic [10:0] temp_in;
   logic        lclk, ss_n, wake_rd, wake_wr, miso, int_out, int_oe_n;
   logic        pwr_on, meas_busy, spec_meas, spec_is_temp, data_valid;
   logic [1:0]  status;
   logic [31:0] seed = 32'h0000000B;
   logic [31:0] pkt;
   int          miscompares = 0;
   int          comparisons = 0;
   int          t0, t1;
   msq_sequencer #(.CLK_PER_US(CPU)) dut (.clk(clk), .srst(srst), .lclk(lclk), .ss_n(ss_n),
      .wake_rd(wake_rd), .wake_wr(wake_wr), .cfg_load(cfg_load), .cfg_rate(cfg_rate),
      .cfg_fast_clk(cfg_fast_clk), .cfg_sleep(cfg_sleep), .cfg_i2c(cfg_i2c),
      .cfg_long_int(cfg_long_int), .bridge_in(bridge_in), .temp_in(temp_in), .miso(miso),
      .int_out(int_out), .int_oe_n(int_oe_n), .pwr_on(pwr_on), .meas_busy(meas_busy),
      .spec_meas(spec_meas), .spec_is_temp(spec_is_temp), .data_valid(data_valid),
      .status(status));
   msq_host_model host (.clk(clk), .miso(miso), .ss_n(ss_n), .lclk(lclk),
      .wake_rd(wake_rd), .wake_wr(wake_wr));
   // 40 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end
   // xorshift source, seeded once
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // typical figure with oscillator slack; 2 percent is far inside it
   function automatic logic near(input int got, input int exp);
      return (got * 50 >= exp * 49) && (got * 50 <= exp * 51);
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // bounded wait for a level; a spent bound ends the run
   task automatic wait_for(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         miscompares++;
         $display("[FAIL] %0t wait ran out", $time);
         print_verdict();
      end
   endtask
   // fresh conversion inputs, then reset and optional config load
   task automatic start(input logic sl, input logic i2c, input logic lng,
                        input logic [1:0] rate, input logic load);
      @(posedge clk);
      srst      <= 1'b1;
      bridge_in <= 14'(xs());
      temp_in   <= 11'(xs());
      repeat (12) @(posedge clk);
      srst         <= 1'b0;
      cfg_load     <= load;
      cfg_sleep    <= sl;
      cfg_i2c      <= i2c;
      cfg_long_int <= lng;
      cfg_rate     <= rate;
      cfg_fast_clk <= 1'b1;
      @(posedge clk) cfg_load <= 1'b0;
      #1;
      `CHK(status, 2'h2, "status after reset")
      `CHK(data_valid, 1'b0, "valid after reset")
      `CHK(spec_is_temp, 1'b1, "special kind after reset")
      repeat (1500 * CPU + 40) @(posedge clk);
      #1;
   endtask
   // one sleep wake from busy rise to result, optional fetch midway
   task automatic meas_cycle(input int us, input logic spec, input logic mid);
      wait_for(meas_busy, 1'b1, 60);
      t0 = $time;
      `CHK(spec_meas, spec, "special kind")
      `CHK(pwr_on, 1'b1, "powered while measuring")
      if (mid)
      begin
         host.fetch(16, pkt);
         `CHK(pkt[31:30], 2'h2, "fetch in cycle not stale")
      end
      wait_for(meas_busy, 1'b0, 40000);
      `CHK(near(($time - t0) / 25, us * CPU), 1'b1, "response time")
      repeat (4) @(posedge clk);
      #1;
      `CHK(status, 2'h0, "status after result")
      `CHK(data_valid, 1'b1, "valid after result")
      `CHK(pwr_on, 1'b0, "powered down after")
   endtask
   // whole packet against inputs; the five trailing zero bits are not compared
   task automatic check_fetch();
      host.fetch(32, pkt);
      `CHK(pkt[31:5], {2'h0, bridge_in, temp_in}, "packet")
      repeat (8) @(posedge clk);
      #1;
      `CHK(status, 2'h2, "stale after fetch")
      `CHK(meas_busy, 1'b0, "fetch woke device")
   endtask
   initial
   begin
      srst = 1'b1;
      cfg_load = 1'b0;
      cfg_rate = 2'h0;
      cfg_fast_clk = 1'b1;
      cfg_sleep = 1'b0;
      cfg_i2c = 1'b1;
      cfg_long_int = 1'b0;
      bridge_in = 14'h0;
      temp_in = 11'h0;
      // defaults: update mode at the fastest rate, never powers down
      start(1'b0, 1'b1, 1'b0, 2'h0, 1'b0);
      wait_for(data_valid, 1'b1, 3000);
      `CHK(status, 2'h0, "first result valid")
      t0 = 0;
      repeat (3000)
      begin
         @(posedge clk);
         #1;
         if (pwr_on !== 1'b1)
            t0++;
      end
      `CHK(t0, 0, "power down at fastest rate")
      $display("test default update done");
      // rate 01: 1500 us period, plus one conversion when special
      start(1'b0, 1'b1, 1'b0, 2'h1, 1'b1);
      wait_for(pwr_on, 1'b0, 20000);
      wait_for(pwr_on, 1'b1, 20000);
      t0 = $time;
      wait_for(pwr_on, 1'b0, 20000);
      wait_for(pwr_on, 1'b1, 20000);
      t1 = ($time - t0) / 25;
      `CHK(near(t1, 1500 * CPU) || near(t1, 2000 * CPU), 1'b1, "update period")
      // fetch inside the power-down gap, so the no-wake check sees an idle core
      wait_for(pwr_on, 1'b0, 20000);
      check_fetch();
      $display("test slow update done");
      // sleep, I2C: write wake first, then read wake with a fetch inside
      start(1'b1, 1'b1, 1'b0, 2'h0, 1'b1);
      `CHK(pwr_on, 1'b0, "asleep after window")
      `CHK(int_oe_n, 1'b0, "interrupt pin driven")
      host.i2c_wake(1'b0);
      meas_cycle(500, 1'b0, 1'b0);
      `CHK(int_out, 1'b1, "interrupt raised")
      check_fetch();
      `CHK(int_out, 1'b0, "interrupt after fetch")
      bridge_in <= 14'(xs());
      host.i2c_wake(1'b1);
      meas_cycle(1500, 1'b1, 1'b1);
      check_fetch();
      // 1 MHz core clock loaded while asleep: same write wake, quarter tick rate
      @(posedge clk);
      cfg_fast_clk <= 1'b0;
      cfg_load     <= 1'b1;
      @(posedge clk) cfg_load <= 1'b0;
      host.i2c_wake(1'b0);
      meas_cycle(1500, 1'b0, 1'b0);
      check_fetch();
      $display("test sleep i2c done");
      // sleep, SPI, long integration: select pulse wakes a full cycle
      start(1'b1, 1'b0, 1'b1, 2'h0, 1'b1);
      `CHK(int_oe_n, 1'b1, "pin released in spi")
      host.spi_wake();
      meas_cycle(4500, 1'b1, 1'b0);
      `CHK(int_out, 1'b0, "no interrupt in spi")
      check_fetch();
      $display("test sleep spi done");
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire

// *** verilog/msq_consts.svh ***
// Purpose: timing, code and reset constants of the measurement sequencer
// Assumes: core clock ticks derived from clk by a prescaler
// Notes: times are in microseconds as printed; tick counts derive in code
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
`define MSQ_CLK_MHZ        40
`define MSQ_MHZ_SLOW       1
`define MSQ_MHZ_FAST       4
`define MSQ_TMR_W          18
`define MSQ_UPD1_00_US     1600
`define MSQ_UPD1_01_US     5000
`define MSQ_UPD1_10_US     25000
`define MSQ_UPD1_11_US     125000
`define MSQ_UPD4_00_US     500
`define MSQ_UPD4_01_US     1500
`define MSQ_UPD4_10_US     6500
`define MSQ_UPD4_11_US     32000
`define MSQ_GAP_00         8'hFF
`define MSQ_GAP_01         8'h7F
`define MSQ_GAP_10         8'h1F
`define MSQ_GAP_11         8'h0F
`define MSQ_RD1_US         4500
`define MSQ_RD4_US         1500
`define MSQ_WR1_US         1500
`define MSQ_WR4_US         500
`define MSQ_RD1_LONG_US    12000
`define MSQ_RD4_LONG_US    4500
`define MSQ_WR1_LONG_US    5500
`define MSQ_WR4_LONG_US    1500
`define MSQ_CMD_WIN_US     1500
`define MSQ_WAKE_LOW_US    8
`define MSQ_ST_VALID       2'h0
`define MSQ_ST_STALE       2'h2
`define MSQ_RATE_RST       2'h0
`define MSQ_FETCH_BITS     6'h10
`endif

// *** verilog/msq_link.sv ***
// Purpose: link-clock shifter that streams the result packet
// Assumes: lclk stands still outside frames; ss_n high ends a frame
// Notes: data changes after falling edges, host samples on rising edges
`include "msq_consts.svh"
`default_nettype none
module msq_link
   import msq_pkg::*;
(
   input  wire logic   lclk,
   input  wire logic   ss_n,
   output logic        miso,
   msq_link_if.link    lnk
);
   msq_link_t s;
   msq_link_t n;

   // first falling edge snapshots the word, later edges shift it out
   always_comb
   begin
      n = s;
      if (s.cnt == 6'h00)
      begin
         n.sh = {lnk.result[30:0], 1'b0};
      end
      else
      begin
         n.sh = {s.sh[30:0], 1'b0};
      end
      if (s.cnt != 6'h3F)
      begin
         n.cnt = s.cnt + 6'h01;
      end
   end

   // the frame select clears the count, since the clock stops after a frame
   always_ff @(negedge lclk or posedge ss_n)
   begin
      if (ss_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign miso        = (s.cnt == 6'h00) ? lnk.result[31] : s.sh[31];
   assign lnk.clocked = (s.cnt != 6'h00);
   assign lnk.fetched = (s.cnt >= `MSQ_FETCH_BITS);
endmodule : msq_link
`default_nettype wire

// *** verilog/msq_link_if.sv ***
// Purpose: carrier between the core and the link-clock shifter
// Assumes: result is held stable by the core while a frame runs
// Notes: clocked and fetched are levels ended by the frame select
`default_nettype none
interface msq_link_if;
   logic [31:0] result;
   logic        clocked;
   logic        fetched;
   modport core (output result, input clocked, input fetched);
   modport link (input result, output clocked, output fetched);
endinterface : msq_link_if
`default_nettype wire

// *** verilog/msq_pkg.sv ***
// Purpose: shared types of the measurement sequencer
// Assumes: constants come from msq_consts.svh
// Notes: state codes are one-hot
`default_nettype none
package msq_pkg;
   typedef enum logic [3:0] {
      MSQ_ST_WIN  = 4'h1,
      MSQ_ST_IDLE = 4'h2,
      MSQ_ST_MEAS = 4'h4,
      MSQ_ST_DOWN = 4'h8
   } msq_state_t;
   typedef struct packed {
      msq_state_t  st;
      logic [7:0]  pre;
      logic [17:0] tmr;
      logic [7:0]  cnt;
      logic        spec;
      logic        spec_temp;
      logic        data_valid;
      logic [1:0]  status;
      logic [31:0] result;
      logic        stale_pend;
      logic        int_lvl;
      logic        pwr;
      logic        seen;
      logic [11:0] sslow;
      logic [2:0]  ss;
      logic [1:0]  ck;
      logic [2:0]  fc;
      logic [2:0]  wr;
      logic [2:0]  rd;
      logic [1:0]  rate;
      logic        f4;
      logic        sleep;
      logic        i2c;
      logic        long_int;
   } msq_core_t;
   typedef struct packed {
      logic [5:0]  cnt;
      logic [31:0] sh;
   } msq_link_t;
endpackage : msq_pkg
`default_nettype wire

// *** verilog/msq_sequencer.sv ***
// Purpose: measurement sequencing and data-availability of a bridge sensor
// Assumes: conversion arithmetic outside; bridge_in/temp_in hold its results
// Notes: CLK_PER_US scales every duration for short simulations
`include "msq_consts.svh"
`default_nettype none
module msq_sequencer
   import msq_pkg::*;
#(
   parameter int CLK_PER_US = `MSQ_CLK_MHZ
)
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        lclk,
   input  wire logic        ss_n,
   input  wire logic        wake_rd,
   input  wire logic        wake_wr,
   input  wire logic        cfg_load,
   input  wire logic [1:0]  cfg_rate,
   input  wire logic        cfg_fast_clk,
   input  wire logic        cfg_sleep,
   input  wire logic        cfg_i2c,
   input  wire logic        cfg_long_int,
   input  wire logic [13:0] bridge_in,
   input  wire logic [10:0] temp_in,
   output logic             miso,
   output logic             int_out,
   output logic             int_oe_n,
   output logic             pwr_on,
   output logic             meas_busy,
   output logic             spec_meas,
   output logic             spec_is_temp,
   output logic             data_valid,
   output logic [1:0]       status
);
   import msq_pkg::*;

   localparam logic [7:0]  PRE_SLOW = 8'(CLK_PER_US - 1);
   localparam logic [7:0]  PRE_FAST = 8'(CLK_PER_US / `MSQ_MHZ_FAST - 1);
   localparam logic [11:0] WAKE_MIN = 12'(`MSQ_WAKE_LOW_US * CLK_PER_US);

   msq_link_if lnk ();
   msq_core_t  s;
   msq_core_t  n;
   logic       ss_lo;
   logic       ss_rise;
   logic       fetch_ev;
   logic       rd_ev;
   logic       wr_ev;
   logic       tick;
   logic       go_cycle;
   logic       wr_res;
   logic [17:0] upd_t;
   logic [17:0] conv_t;
   logic [17:0] rd_t;
   logic [7:0]  gap;

   // microseconds to core ticks at the selected core clock
   function automatic logic [17:0] to_ticks(input int us, input logic f4);
      return f4 ? 18'(us * `MSQ_MHZ_FAST) : 18'(us * `MSQ_MHZ_SLOW);
   endfunction

   // period and special gap per rate code
   always_comb
   begin
      unique case (s.rate)
         2'h0:
         begin
            upd_t = s.f4 ? to_ticks(`MSQ_UPD4_00_US, 1'b1)
                         : to_ticks(`MSQ_UPD1_00_US, 1'b0);
            gap   = `MSQ_GAP_00;
         end
         2'h1:
         begin
            upd_t = s.f4 ? to_ticks(`MSQ_UPD4_01_US, 1'b1)
                         : to_ticks(`MSQ_UPD1_01_US, 1'b0);
            gap   = `MSQ_GAP_01;
         end
         2'h2:
         begin
            upd_t = s.f4 ? to_ticks(`MSQ_UPD4_10_US, 1'b1)
                         : to_ticks(`MSQ_UPD1_10_US, 1'b0);
            gap   = `MSQ_GAP_10;
         end
         2'h3:
         begin
            upd_t = s.f4 ? to_ticks(`MSQ_UPD4_11_US, 1'b1)
                         : to_ticks(`MSQ_UPD1_11_US, 1'b0);
            gap   = `MSQ_GAP_11;
         end
      endcase
   end

   // one conversion equals a bridge-only wake response
   always_comb
   begin
      if (s.long_int)
      begin
         conv_t = s.f4 ? to_ticks(`MSQ_WR4_LONG_US, 1'b1)
                       : to_ticks(`MSQ_WR1_LONG_US, 1'b0);
         rd_t   = s.f4 ? to_ticks(`MSQ_RD4_LONG_US, 1'b1)
                       : to_ticks(`MSQ_RD1_LONG_US, 1'b0);
      end
      else
      begin
         conv_t = s.f4 ? to_ticks(`MSQ_WR4_US, 1'b1)
                       : to_ticks(`MSQ_WR1_US, 1'b0);
         rd_t   = s.f4 ? to_ticks(`MSQ_RD4_US, 1'b1)
                       : to_ticks(`MSQ_RD1_US, 1'b0);
      end
   end

   // next state of the whole core
   always_comb
   begin
      n        = s;
      wr_res   = 1'b0;
      go_cycle = 1'b0;
      // two flops before any use; a third flop only for edge detection
      n.ss = {s.ss[1:0], ss_n};
      n.ck = {s.ck[0], lnk.clocked};
      n.fc = {s.fc[1:0], lnk.fetched};
      n.wr = {s.wr[1:0], wake_wr};
      n.rd = {s.rd[1:0], wake_rd};
      ss_lo    = ~s.ss[1];
      ss_rise  = s.ss[1] & ~s.ss[2];
      fetch_ev = s.fc[1] & ~s.fc[2];
      // prescaler gives one tick per core clock period
      tick  = (s.pre == 8'h00);
      n.pre = tick ? (s.f4 ? PRE_FAST : PRE_SLOW) : s.pre - 8'h01;
      // select low time, and whether any clock edge came in the frame
      n.sslow = ss_lo ? ((s.sslow == 12'hFFF) ? s.sslow : s.sslow + 12'h001) : 12'h000;
      if (s.ck[1])
      begin
         n.seen = 1'b1;
      end
      else if (!ss_lo && !ss_rise)
      begin
         n.seen = 1'b0;
      end
      // in SPI mode a clockless select pulse of at least WAKE_MIN is a read wake; a fetch never wakes
      rd_ev = s.i2c ? (s.rd[1] & ~s.rd[2])
                    : (ss_rise & ~s.seen & (s.sslow >= WAKE_MIN));
      wr_ev = s.i2c & s.wr[1] & ~s.wr[2];
      // status goes stale after a completed fetch
      if (fetch_ev)
      begin
         n.stale_pend = 1'b1;
         n.int_lvl    = 1'b0;
      end
      if (cfg_load)
      begin
         n.rate     = cfg_rate;
         n.f4       = cfg_fast_clk;
         n.sleep    = cfg_sleep;
         n.i2c      = cfg_i2c;
         n.long_int = cfg_long_int;
      end
      unique case (s.st)
         MSQ_ST_WIN:
         begin
            if (tick)
            begin
               n.tmr = s.tmr - 18'h00001;
            end
            if (tick && s.tmr == 18'h00000)
            begin
               if (s.sleep)
               begin
                  n.st  = MSQ_ST_IDLE;
                  n.pwr = 1'b0;
               end
               else
               begin
                  go_cycle = 1'b1;
               end
            end
         end
         MSQ_ST_IDLE:
         begin
            if (s.sleep && rd_ev)
            begin
               n.st         = MSQ_ST_MEAS;
               n.tmr        = rd_t;
               n.spec       = 1'b1;
               n.pwr        = 1'b1;
               n.stale_pend = 1'b1;
               n.int_lvl    = 1'b0;
            end
            else if (s.sleep && wr_ev)
            begin
               n.st         = MSQ_ST_MEAS;
               n.tmr        = conv_t;
               n.spec       = 1'b0;
               n.pwr        = 1'b1;
               n.stale_pend = 1'b1;
               n.int_lvl    = 1'b0;
            end
         end
         MSQ_ST_MEAS:
         begin
            if (tick && s.tmr != 18'h00000)
            begin
               n.tmr = s.tmr - 18'h00001;
            end
            // the write waits while a frame could be reading the word
            if (s.tmr == 18'h00000 && !ss_lo)
            begin
               wr_res       = 1'b1;
               n.result     = {`MSQ_ST_VALID, bridge_in, temp_in, 5'h00};
               n.status     = `MSQ_ST_VALID;
               n.data_valid = 1'b1;
               n.stale_pend = 1'b0;
               n.int_lvl    = s.i2c;
               if (s.spec && !s.sleep)
               begin
                  n.spec_temp = ~s.spec_temp;
               end
               if (s.sleep)
               begin
                  n.st  = MSQ_ST_IDLE;
                  n.pwr = 1'b0;
               end
               else if (s.rate == 2'h0)
               begin
                  go_cycle = 1'b1;
               end
               else
               begin
                  n.st  = MSQ_ST_DOWN;
                  n.tmr = upd_t - conv_t;
                  n.pwr = 1'b0;
               end
            end
         end
         MSQ_ST_DOWN:
         begin
            if (tick)
            begin
               n.tmr = s.tmr - 18'h00001;
            end
            if (tick && s.tmr <= 18'h00001)
            begin
               go_cycle = 1'b1;
            end
         end
      endcase
      // a special cycle carries one extra conversion for the bridge after it
      if (go_cycle)
      begin
         n.st   = MSQ_ST_MEAS;
         n.pwr  = 1'b1;
         n.spec = (s.cnt == gap);
         n.tmr  = (s.cnt == gap) ? 18'(conv_t << 1) : conv_t;
         n.cnt  = (s.cnt == gap) ? 8'h00 : s.cnt + 8'h01;
      end
      // deferred stale marking keeps the word steady during a frame
      if (s.stale_pend && !ss_lo && !wr_res)
      begin
         n.status         = `MSQ_ST_STALE;
         n.result[31:30]  = `MSQ_ST_STALE;
         n.stale_pend     = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s            <= '0;
         s.st         <= MSQ_ST_WIN;
         s.tmr        <= 18'(`MSQ_CMD_WIN_US * `MSQ_MHZ_FAST);
         s.status     <= `MSQ_ST_STALE;
         s.result     <= {`MSQ_ST_STALE, 30'h00000000};
         s.pwr        <= 1'b1;
         s.spec_temp  <= 1'b1;
         s.ss         <= 3'h7;
         s.rate       <= `MSQ_RATE_RST;
         s.f4         <= 1'b1;
         s.i2c        <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   msq_link u_link (
      .lclk (lclk),
      .ss_n (ss_n),
      .miso (miso),
      .lnk  (lnk.link)
   );

   assign lnk.result   = s.result;
   assign int_out      = s.int_lvl;
   assign int_oe_n     = ~s.i2c; // drives only in I2C mode
   assign pwr_on       = s.pwr;
   assign meas_busy    = (s.st == MSQ_ST_MEAS);
   assign spec_meas    = (s.st == MSQ_ST_MEAS) && s.spec;
   assign spec_is_temp = s.spec_temp;
   assign data_valid   = s.data_valid;
   assign status       = s.status;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   chk_fast_no_down: assert property (
      (s.rate == 2'h0 && !s.sleep) |-> ##1 (s.st != MSQ_ST_DOWN) || $changed(s.rate))
      else $error("power-down at fastest rate");
   chk_down_unpowered: assert property (
      (s.st == MSQ_ST_DOWN) |-> !pwr_on && !meas_busy)
      else $error("powered during down period");
   chk_word_held: assert property (
      (ss_lo && $past(ss_lo)) |-> $stable(s.result))
      else $error("result changed during frame");
   chk_valid_first: assert property (
      $rose(data_valid) |-> $past(s.st) == MSQ_ST_MEAS && status == `MSQ_ST_VALID)
      else $error("valid without a written result");
   chk_int_new_data: assert property (
      $rose(int_out) |-> s.i2c && status == `MSQ_ST_VALID && $past(meas_busy))
      else $error("interrupt without new data");
   chk_fetch_stale: assert property (
      (fetch_ev && !wr_res) |-> ##[1:3] (status == `MSQ_ST_STALE) || ss_lo)
      else $error("status not stale after fetch");
   chk_wake_sleep: assert property (
      (s.st == MSQ_ST_IDLE) ##1 (s.st == MSQ_ST_MEAS) |-> s.sleep && pwr_on)
      else $error("wake outside sleep mode");
   chk_special_len: assert property (
      (go_cycle && s.cnt == gap) |=> spec_meas && s.tmr == 18'(conv_t << 1))
      else $error("special cycle length wrong");
   chk_special_gap: assert property (
      (go_cycle && s.cnt != gap) |=> !spec_meas && s.cnt == $past(s.cnt) + 8'h01)
      else $error("special inserted too early");
   chk_meas_stale: assert property (
      (s.st == MSQ_ST_IDLE && s.sleep && (rd_ev || wr_ev)) |=> ##[0:2] !ss_lo
      |-> ##[0:1] status == `MSQ_ST_STALE || !meas_busy)
      else $error("valid status during measurement");
endmodule : msq_sequencer
`default_nettype wire
